/* File: logic/lin_can_gateway_modes.sv */
// Mode, translation and schedule logic of the LIN/CAN gateway with AHB-Lite registers
module lin_can_gateway_modes
    import lin_can_gw_pkg::*;
#(
    parameter int          MS_CYCLES = MS_CYCLES_DF,
    parameter logic [15:0] FW_VER    = 16'h0001,  // Arbitrary value
    parameter logic [15:0] HW_VER    = 16'h0001   // Arbitrary value
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic [1:0]  stored_start,
    output logic [1:0]       startup_cfg,
    input  wire logic        pc_cable,
    input  wire logic        lin_rxd,
    input  wire logic        lin_hdr_valid,
    input  wire logic [5:0]  lin_hdr_id,
    input  wire logic        lin_rx_valid,
    input  wire lin_frame_t  lin_rx,
    input  wire logic        lin_err,
    input  wire logic [5:0]  lin_err_id,
    output logic             lin_hdr_req,
    input  wire logic        lin_hdr_ready,
    output logic [5:0]       lin_hdr_out_id,
    output logic             lin_resp_valid,
    output lin_frame_t       lin_resp,
    output logic             lin_resp_enh,
    output logic             lin_wake,
    input  wire logic        can_rx_valid,
    input  wire can_frame_t  can_rx,
    output logic             can_tx_valid,
    input  wire logic        can_tx_ready,
    output can_frame_t       can_tx,
    output logic             mon_valid,
    output lin_frame_t       mon,
    output logic             power_down
);
    typedef struct packed {
        mode_t                                mode;
        logic [1:0]                           boot_cnt;
        logic [1:0]                           start_code;
        logic                                 gw_on;
        logic [31:0]                          idle_ms;
        logic [31:0]                          name;
        tab_arr_t                             tab;
        slot_t [SCHED_LISTS-1:0][SLOTS-1:0]   slots;
        logic [SCHED_LISTS-1:0][6:0]          slen;
        logic [IDS-1:0][63:0]                 rdata;
        resp_cfg_t [IDS-1:0]                  rcfg;
        logic [IDS-1:0]                       pend;
        logic [1:0]                           act;
        logic [1:0]                           nxt;
        logic                                 nxt_v;
        logic [5:0]                           idx;
        sch_t                                 sst;
        logic [7:0]                           dly;
        logic [31:0]                          ms_cnt;
        logic [31:0]                          idle_cnt;
        logic                                 pdown;
        logic [7:0]                           wake_ms;
        logic                                 wake_on;
        can_frame_t                           ctx;
        logic                                 ctx_v;
        lin_frame_t                           resp;
        logic                                 resp_enh;
        logic                                 resp_v;
        lin_frame_t                           mon;
        logic                                 mon_v;
        logic [11:0]                          addr;
        logic                                 dwr;
        logic                                 drd;
        logic                                 rdw;
        logic [31:0]                          rdat;
        logic [31:0]                          tlo;
        logic [31:0]                          thi;
        logic [1:0]                           cab_s;
        logic [1:0]                           lin_s;
    } state_t;

    state_t s;
    state_t n;

    // Startup code to mode; two bits cannot name a PC mode
    function automatic mode_t start_mode(logic [1:0] c);
        unique case (c)
            2'h0: start_mode = M_GW_MS;
            2'h1: start_mode = M_GW_S;
            2'h2: start_mode = M_MS;
            2'h3: start_mode = M_S;
        endcase
    endfunction

    // First entry by LIN id: error mapping or direction
    function automatic logic [7:0] find_lin(tab_arr_t t, logic [5:0] id, dir_t d, logic em);
        find_lin = 8'h00;
        for (int i = TAB_ENTRIES - 1; i >= 0; i--) begin
            if (t[i].lin_id == id && (em ? t[i].err_map : t[i].dir == d)) begin
                find_lin = {1'b1, 7'(i)};
            end
        end
    endfunction

    // First entry by CAN id and format; FN_NONE means CAN-to-LIN buffering
    function automatic logic [7:0] find_can(tab_arr_t t, can_frame_t f, func_t fn);
        find_can = 8'h00;
        for (int i = TAB_ENTRIES - 1; i >= 0; i--) begin
            if (t[i].can_id == f.id && t[i].ext == f.ext && t[i].func == fn
                && (fn != FN_NONE || t[i].dir == DIR_C2L)) begin
                find_can = {1'b1, 7'(i)};
            end
        end
    endfunction

    logic       tick;
    logic       gw;
    logic       mst;
    logic       pcm;
    logic       pc;
    logic       wrap;
    logic [7:0] h;
    tcmd_t      tc;
    pc_cmd_t    pcw;
    slot_t      cur;

    always_comb begin
        tick = s.ms_cnt == 32'(MS_CYCLES - 1);
        gw   = s.mode inside {M_GW_MS, M_GW_S};
        mst  = s.mode inside {M_GW_MS, M_MS, M_PC_MS};
        pcm  = s.mode inside {M_PC_S, M_PC_MS};
        pc   = s.cab_s[1];
        cur  = s.slots[s.act][s.idx];
        wrap = s.sst == S_DELAY && s.dly == 8'h00 && 7'(s.idx) + 7'h01 >= s.slen[s.act];
        tc   = tcmd_t'(hwdata);
        pcw  = pc_cmd_t'(hwdata);
        h    = 8'h00;
        n    = s;
        n.resp_v = 1'b0;
        n.mon_v  = 1'b0;
        // Pin synchronisers and millisecond divider
        n.cab_s  = {s.cab_s[0], pc_cable};
        n.lin_s  = {s.lin_s[0], lin_rxd};
        n.ms_cnt = tick ? 32'h0 : s.ms_cnt + 32'h1;

        // boot mode choice
        // Waits for the synchronisers to fill before sampling the cable
        if (s.mode == M_BOOT) begin
            n.boot_cnt = s.boot_cnt + 2'h1;
            if (s.boot_cnt == BOOT_WAIT) begin
                n.start_code = stored_start;
                n.gw_on      = 1'b1;
                n.mode       = pc ? M_PC_S : start_mode(stored_start);
            end
        end

        // wake-up duration
        // Runs ms+1 ticks so the partial first tick never cuts it short; a restart below wins
        if (s.wake_on && tick) begin
            n.wake_ms = (s.wake_ms != 8'h00) ? s.wake_ms - 8'h01 : 8'h00;
            n.wake_on = s.wake_ms != 8'h00;
        end

        // Bus slave: reads take one wait state, writes none
        n.dwr = 1'b0;
        if (s.drd && s.rdw) begin
            n.drd = 1'b0;
        end
        if (s.drd && !s.rdw) begin
            n.rdw = 1'b1;
            unique case (s.addr)
                A_CTRL:  n.rdat = {29'h0, s.gw_on, s.start_code};
                A_STAT:  n.rdat = {17'h0, pc, s.idx, s.nxt_v, s.act, s.gw_on, s.pdown, s.mode};
                A_IDLE:  n.rdat = s.idle_ms;
                A_PC:    n.rdat = {16'h0, s.wake_ms, 6'h0, s.mode == M_PC_MS, s.wake_on};
                A_NAME:  n.rdat = s.name;
                A_VER:   n.rdat = {HW_VER, FW_VER};
                A_TLO:   n.rdat = s.tlo;
                A_THI:   n.rdat = s.thi;
                default: n.rdat = 32'h0;
            endcase
        end
        if (s.dwr) begin
            unique case (s.addr)
                A_CTRL: begin
                    n.start_code = hwdata[1:0];
                    n.gw_on      = hwdata[2];
                end
                A_IDLE: n.idle_ms = hwdata;
                A_NAME: n.name = hwdata;
                A_TLO:  n.tlo = hwdata;
                A_THI:  n.thi = hwdata;
                A_PC: begin
                    if (pcm) begin
                        n.mode = pcw.master ? M_PC_MS : M_PC_S;
                    end
                    if (s.mode == M_PC_MS && pcw.wake && pcw.ms != 8'h00) begin
                        n.wake_ms = pcw.ms;
                        n.wake_on = 1'b1;
                    end
                end
                A_TCMD: begin
                    if (tc.kind == TK_GW && tc.idx < 7'(TAB_ENTRIES)) begin
                        n.tab[tc.idx] = tab_entry_t'({s.thi, s.tlo});
                    end
                    if (tc.kind == TK_SLOT && tc.idx < 7'(SLOTS)) begin
                        n.slots[tc.list][tc.idx[5:0]] = slot_t'(s.tlo[13:0]);
                    end
                    if (tc.kind == TK_SLEN && tc.idx <= 7'(SLOTS)) begin
                        n.slen[tc.list] = tc.idx;
                    end
                    if (tc.kind == TK_DATA && tc.idx < 7'(IDS)) begin
                        n.rdata[tc.idx[5:0]] = {s.thi, s.tlo};
                    end
                    if (tc.kind == TK_RCFG && tc.idx < 7'(IDS) && s.tlo[3:0] <= 4'h8) begin
                        n.rcfg[tc.idx[5:0]] = resp_cfg_t'(s.tlo[4:0]);
                    end
                end
                default: ;
            endcase
        end
        if (hsel && htrans[1] && hready) begin
            n.addr = haddr[11:0];
            n.dwr  = hwrite;
            n.drd  = !hwrite;
            n.rdw  = 1'b0;
        end

        // CAN transmit slot frees on acceptance
        if (s.ctx_v && can_tx_ready) begin
            n.ctx_v = 1'b0;
        end

        if (pcm && lin_rx_valid) begin
            n.mon   = lin_rx;
            n.mon_v = 1'b1;
        end

        if (gw && s.gw_on && lin_rx_valid && !n.ctx_v) begin
            h = find_lin(s.tab, lin_rx.id, DIR_L2C, 1'b0);
            if (h[7]) begin
                n.ctx   = {s.tab[h[6:0]].ext, s.tab[h[6:0]].can_id, lin_rx.len, lin_rx.data};
                n.ctx_v = 1'b1;
            end
        end
        // error frame carries the LIN id; takes the slot over a forward
        if (gw && s.gw_on && lin_err && (!s.ctx_v || can_tx_ready)) begin
            h = find_lin(s.tab, lin_err_id, DIR_NONE, 1'b1);
            if (h[7]) begin
                n.ctx   = {s.tab[h[6:0]].ext, s.tab[h[6:0]].can_id, 4'h1, {58'h0, lin_err_id}};
                n.ctx_v = 1'b1;
            end
        end

        // Header answers
        if (lin_hdr_valid) begin
            if (gw && s.gw_on && s.pend[lin_hdr_id]) begin
                n.pend[lin_hdr_id] = 1'b0;
                n.resp_v           = 1'b1;
            end
            if (!gw && s.mode != M_BOOT && s.rcfg[lin_hdr_id].len != 4'h0) begin
                n.resp_v = 1'b1;
            end
            n.resp     = {lin_hdr_id, s.rcfg[lin_hdr_id].len, s.rdata[lin_hdr_id]};
            n.resp_enh = s.rcfg[lin_hdr_id].enh;
        end

        // CAN frames into gateway modes
        if (gw && can_rx_valid) begin
            h = find_can(s.tab, can_rx, FN_GW_SW);
            if (h[7]) begin
                n.gw_on = can_rx.data[63:56] != 8'h00;
            end
            h = find_can(s.tab, can_rx, FN_SCHED);
            if (h[7] && can_rx.data[63:56] < 8'(SCHED_LISTS)
                && s.slen[can_rx.data[57:56]] != 7'h0) begin
                n.nxt   = can_rx.data[57:56];
                n.nxt_v = 1'b1;
            end
            h = find_can(s.tab, can_rx, FN_NONE);
            if (h[7] && s.gw_on) begin
                n.rdata[s.tab[h[6:0]].lin_id] = can_rx.data;
                n.pend[s.tab[h[6:0]].lin_id]  = 1'b1;
            end
        end

        // schedule runner over the active list
        unique case (s.sst)
            S_IDLE: begin
                n.idx = 6'h0;
                if (mst && !s.pdown && s.slen[s.act] != 7'h0) begin
                    n.sst = S_HDR;
                end
            end
            S_HDR: begin
                if (lin_hdr_ready) begin
                    n.sst = S_FRAME;
                end
            end
            S_FRAME: begin
                // Engine reports every frame end, a timeout as an error
                if (lin_rx_valid || lin_err) begin
                    n.sst = S_DELAY;
                    n.dly = cur.delay_ms;
                end
            end
            S_DELAY: begin
                if (s.dly != 8'h00) begin
                    n.dly = tick ? s.dly - 8'h01 : s.dly;
                end else begin
                    n.idx = wrap ? 6'h0 : s.idx + 6'h1;
                    n.sst = S_HDR;
                    if (wrap && s.nxt_v) begin
                        n.act   = s.nxt;
                        // A different request landing now stays pending
                        n.nxt_v = n.nxt != s.nxt;
                    end
                end
            end
        endcase
        if (!mst || s.pdown) begin
            n.sst = S_IDLE;
        end

        if (lin_rx_valid || lin_hdr_valid || lin_err || can_rx_valid || pc || pcm
            || s.mode == M_BOOT || s.idle_ms == 32'h0) begin
            n.idle_cnt = 32'h0;
        end else if (tick && !s.pdown) begin
            n.idle_cnt = s.idle_cnt + 32'h1;
            n.pdown    = n.idle_cnt >= s.idle_ms;
        end
        if (s.pdown && (!s.lin_s[1] || can_rx_valid || pc)) begin
            n.pdown    = 1'b0;
            n.idle_cnt = 32'h0;
        end
    end

    // One register for all state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    // Outputs
    assign hreadyout      = !(s.drd && !s.rdw);
    assign hresp          = 1'b0;
    assign hrdata         = s.rdat;
    assign startup_cfg    = s.start_code;
    assign lin_hdr_req    = s.sst == S_HDR;
    assign lin_hdr_out_id = cur.id;
    assign lin_resp_valid = s.resp_v;
    assign lin_resp       = s.resp;
    assign lin_resp_enh   = s.resp_enh;
    assign lin_wake       = s.wake_on;
    assign can_tx_valid   = s.ctx_v;
    assign can_tx         = s.ctx;
    assign mon_valid      = s.mon_v;
    assign mon            = s.mon;
    assign power_down     = s.pdown;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Boot, mode, schedule, translation, wake-up and power-down checks
    a_boot_pc_mode: assert property (s.mode == M_BOOT && s.boot_cnt == BOOT_WAIT && pc |=> s.mode == M_PC_S)
        else $error("cabled boot missed PC slave mode");
    a_boot_stored: assert property (s.mode == M_BOOT && s.boot_cnt == BOOT_WAIT && !pc
        |=> s.mode inside {M_GW_MS, M_GW_S, M_MS, M_S}) else $error("illegal startup mode");
    a_sched_wrap: assert property (wrap && mst && !s.pdown |=> s.idx == 6'h0 && lin_hdr_req)
        else $error("schedule did not restart");
    a_sched_defer: assert property (s.nxt_v && !wrap |=> s.act == $past(s.act))
        else $error("schedule switched mid pass");
    a_c2l_once: assert property (lin_hdr_valid && gw && s.gw_on && s.pend[lin_hdr_id] && !can_rx_valid
        |=> lin_resp_valid && !s.pend[$past(lin_hdr_id)]) else $error("buffered response not sent once");
    a_gw_switch: assert property (gw && can_rx_valid && find_can(s.tab, can_rx, FN_GW_SW) != 8'h00
        |=> s.gw_on == ($past(can_rx.data[63:56]) != 8'h00)) else $error("gateway switch wrong");
    a_xlate_off: assert property (!s.gw_on && !n.gw_on && !s.ctx_v |=> !can_tx_valid)
        else $error("forwarding while translation off");
    a_l2c_fwd: assert property (gw && s.gw_on && lin_rx_valid && !lin_err && !s.ctx_v
        && find_lin(s.tab, lin_rx.id, DIR_L2C, 1'b0) != 8'h00 |=> can_tx_valid && can_tx.data == $past(lin_rx.data))
        else $error("LIN frame not forwarded");
    a_wake_start: assert property (s.dwr && s.addr == A_PC && s.mode == M_PC_MS && pcw.wake && pcw.ms != 8'h00
        |=> lin_wake [*2]) else $error("wake-up not driven");
    a_pdown_wake: assert property (s.pdown && pc |=> !power_down)
        else $error("cable did not wake device");
endmodule

/* File: logic/lin_can_gw_pkg.sv */
// Shared constants and types of the LIN/CAN gateway mode logic
package lin_can_gw_pkg;
    // Table sizes
    localparam int TAB_ENTRIES  = 67;
    localparam int SLOTS        = 64;
    localparam int IDS          = 64;
    localparam int SCHED_LISTS  = 4;
    // Timing: one millisecond tick from the 25 MHz bus clock
    localparam int CLK_HZ       = 25_000_000;
    localparam int TICK_US      = 1000;
    localparam int MS_CYCLES_DF = CLK_HZ / 1_000_000 * TICK_US;
    localparam logic [1:0] BOOT_WAIT = 2'h3;
    // Register byte offsets
    localparam logic [11:0] A_CTRL = 12'h000;
    localparam logic [11:0] A_STAT = 12'h004;
    localparam logic [11:0] A_IDLE = 12'h008;
    localparam logic [11:0] A_PC   = 12'h00C;
    localparam logic [11:0] A_NAME = 12'h010;
    localparam logic [11:0] A_VER  = 12'h014;
    localparam logic [11:0] A_TLO  = 12'h018;
    localparam logic [11:0] A_THI  = 12'h01C;
    localparam logic [11:0] A_TCMD = 12'h020;
    // Table commit kinds
    localparam logic [2:0] TK_GW   = 3'h0;
    localparam logic [2:0] TK_SLOT = 3'h1;
    localparam logic [2:0] TK_SLEN = 3'h2;
    localparam logic [2:0] TK_DATA = 3'h3;
    localparam logic [2:0] TK_RCFG = 3'h4;

    typedef enum logic [2:0] {M_BOOT, M_GW_MS, M_GW_S, M_MS, M_S, M_PC_S, M_PC_MS} mode_t;
    typedef enum logic [1:0] {DIR_NONE, DIR_L2C, DIR_C2L} dir_t;
    typedef enum logic [1:0] {FN_NONE, FN_GW_SW, FN_SCHED} func_t;
    typedef enum logic [1:0] {S_IDLE, S_HDR, S_FRAME, S_DELAY} sch_t;

    typedef struct packed {
        logic [22:0] rsv;
        logic        err_map;
        func_t       func;
        dir_t        dir;
        logic [5:0]  lin_id;
        logic        ext;
        logic [28:0] can_id;
    } tab_entry_t;
    typedef tab_entry_t [TAB_ENTRIES-1:0] tab_arr_t;

    typedef struct packed {
        logic [7:0] delay_ms;
        logic [5:0] id;
    } slot_t;

    typedef struct packed {
        logic       enh;
        logic [3:0] len;
    } resp_cfg_t;

    typedef struct packed {
        logic [12:0] rsv;
        logic [2:0]  kind;
        logic [1:0]  list;
        logic [6:0]  rsv2;
        logic [6:0]  idx;
    } tcmd_t;

    typedef struct packed {
        logic [15:0] rsv;
        logic [7:0]  ms;
        logic [5:0]  rsv2;
        logic        master;
        logic        wake;
    } pc_cmd_t;

    typedef struct packed {
        logic [5:0]  id;
        logic [3:0]  len;
        logic [63:0] data;
    } lin_frame_t;

    typedef struct packed {
        logic        ext;
        logic [28:0] id;
        logic [3:0]  len;
        logic [63:0] data;
    } can_frame_t;
endpackage

/* File: tb/lin_can_far_end.sv */
// Far-side model: a CAN controller that stalls before accepting, and a LIN engine
module lin_can_far_end
    import lin_can_gw_pkg::*;
#(
    parameter int STALL = 2
) (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       can_tx_valid,
    input  wire can_frame_t can_tx,
    output logic            can_tx_ready,
    input  wire logic       lin_hdr_req,
    output logic            lin_hdr_ready,
    output logic            got_can,
    output can_frame_t      last_can
);
    logic [3:0] wait_cnt;
    // Busy controller: frame taken only after STALL cycles, so the held frame is exercised
    assign can_tx_ready  = can_tx_valid && (wait_cnt == 4'(STALL));
    assign lin_hdr_ready = lin_hdr_req;
    // Capture each accepted frame for the bench
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wait_cnt <= 4'h0;
            got_can  <= 1'b0;
            last_can <= '0;
        end else begin
            got_can  <= can_tx_valid && can_tx_ready;
            wait_cnt <= (can_tx_valid && !can_tx_ready) ? wait_cnt + 4'h1 : 4'h0;
            if (can_tx_valid && can_tx_ready) begin
                last_can <= can_tx;
            end
        end
    end
endmodule

/* File: tb/tb_lin_can_gateway_modes.sv */
// Self-checking bench of the gateway mode logic
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin fails++; $display("FAIL %s exp %h got %h", n, e, s); end end
module tb_lin_can_gateway_modes import lin_can_gw_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, lin_hdr_valid = 1'b0, lin_rx_valid = 1'b0;
    logic        can_rx_valid = 1'b0, lin_err = 1'b0, hready, can_tx_ready, lin_hdr_ready, got_can, seen;
    logic        pc_cable = 1'b0, lin_wake;
    logic        lin_resp_valid, can_tx_valid, lin_hdr_req;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [63:0] rdat;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [5:0]  lin_hdr_id = 6'h0, lin_err_id = 6'h0;
    lin_frame_t  lin_rx = '0, lin_resp;
    can_frame_t  can_rx = '0, can_tx, last_can;
    int          fails = 0, num_checks = 0;

    lin_can_gateway_modes #(.MS_CYCLES(4)) DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hreadyout(hready), .hresp(), .hrdata, .stored_start(2'h1), .startup_cfg(), .pc_cable,
        .lin_rxd(1'b1), .lin_hdr_valid, .lin_hdr_id, .lin_rx_valid, .lin_rx, .lin_err, .lin_err_id,
        .lin_hdr_req, .lin_hdr_ready, .lin_hdr_out_id(), .lin_resp_valid, .lin_resp, .lin_resp_enh(), .lin_wake,
        .can_rx_valid, .can_rx, .can_tx_valid, .can_tx_ready, .can_tx, .mon_valid(), .mon(), .power_down());
    lin_can_far_end #(.STALL(2)) far (.hclk, .hresetn, .can_tx_valid, .can_tx, .can_tx_ready, .lin_hdr_req,
        .lin_hdr_ready, .got_can, .last_can);

    // Free-running 25 MHz clock
    always #20 hclk = ~hclk;

    task automatic give_verdict;
        if (fails == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Bounded wait for hready at a rising edge
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge hclk);
        while (hready !== 1'b1) begin
            n++;
            if (n > 20) begin
                fails++;
                give_verdict;
            end
            @(posedge hclk);
        end
    endtask
    // One single AHB-Lite word transfer; read data lands in rd
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {20'h0, a};
        wait_rdy;
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= d;
        wait_rdy;
        rd = hrdata;
    endtask
    // Stage a translation entry, then commit it
    task automatic ent(input logic [6:0] i, input logic [5:0] lid, input dir_t dr, input func_t fn, input logic x,
                       input logic [28:0] cid, input logic em = 1'b0);
        tab_entry_t e;
        tcmd_t      c;
        e = '{23'h0, em, fn, dr, lid, x, cid};
        c = '0;
        c.kind = TK_GW;
        c.idx = i;
        bus(1'b1, A_TLO, e[31:0]);
        bus(1'b1, A_THI, e[63:32]);
        bus(1'b1, A_TCMD, c);
    endtask
    // One-cycle event pulses, then a bounded watch of the answer to a LIN frame or header, a two-cycle wait after a CAN frame
    task automatic lin_frame(input logic [5:0] id, input logic [63:0] dat);
        lin_rx       <= '{id, 4'h8, dat};
        lin_rx_valid <= 1'b1;
        @(posedge hclk);
        lin_rx_valid <= 1'b0;
        seen = 1'b0;
        repeat (10) begin
            @(posedge hclk);
            if (got_can === 1'b1) seen = 1'b1;
        end
    endtask
    task automatic can_frame(input logic [28:0] id, input logic [63:0] dat);
        can_rx       <= '{1'b0, id, 4'h8, dat};
        can_rx_valid <= 1'b1;
        @(posedge hclk);
        can_rx_valid <= 1'b0;
        repeat (2) @(posedge hclk);
    endtask
    task automatic header(input logic [5:0] id);
        lin_hdr_id    <= id;
        lin_hdr_valid <= 1'b1;
        @(posedge hclk);
        lin_hdr_valid <= 1'b0;
        seen = 1'b0;
        repeat (3) begin
            @(posedge hclk);
            if (lin_resp_valid === 1'b1) begin
                seen = 1'b1;
                rdat = lin_resp.data;
            end
        end
    endtask

    // Stored gateway-slave mode, gateway on, unmapped read gives zero
    task automatic t_startup;
        bus(1'b0, A_STAT, 32'h0);
        `CHK("mode", 3'h2, rd[2:0])
        `CHK("gw_on", 1'b1, rd[4])
        bus(1'b0, 12'hFFC, 32'h0);
        `CHK("unmapped", 32'h0, rd)
    endtask
    // Extended and standard forwarding; a no-translation entry stays silent
    task automatic t_forward;
        ent(7'h00, 6'h05, DIR_L2C, FN_NONE, 1'b1, 29'h1ABCDEF0);
        ent(7'h42, 6'h06, DIR_L2C, FN_NONE, 1'b0, 29'h123);
        ent(7'h02, 6'h07, DIR_NONE, FN_NONE, 1'b0, 29'h321);
        lin_frame(6'h05, 64'h1122334455667788);
        `CHK("ext id", {1'b1, 29'h1ABCDEF0}, {last_can.ext, last_can.id})
        `CHK("fwd data", 64'h1122334455667788, last_can.data)
        lin_frame(6'h06, 64'hCAFE);
        `CHK("std id", {1'b0, 29'h123}, {last_can.ext, last_can.id})
        lin_frame(6'h07, 64'h0);
        `CHK("none fwd", 1'b0, seen)
    endtask
    // Buffered CAN data answers one header only
    task automatic t_c2l;
        ent(7'h03, 6'h09, DIR_C2L, FN_NONE, 1'b0, 29'h2A0);
        can_frame(29'h2A0, 64'hA55A0F0F12345678);
        header(6'h09);
        `CHK("resp", 64'hA55A0F0F12345678, rdat)
        header(6'h09);
        `CHK("resp once", 1'b0, seen)
    endtask
    // Control frame: zero byte turns forwarding off, nonzero back on
    task automatic t_switch;
        ent(7'h04, 6'h00, DIR_NONE, FN_GW_SW, 1'b0, 29'h100);
        can_frame(29'h100, 64'h00FF000000000000);
        bus(1'b0, A_STAT, 32'h0);
        `CHK("gw off", 1'b0, rd[4])
        lin_frame(6'h05, 64'h1);
        `CHK("off fwd", 1'b0, seen)
        can_frame(29'h100, 64'h3C00000000000000);
        lin_frame(6'h05, 64'h2);
        `CHK("on fwd", 1'b1, seen)
    endtask
    // LIN error on a mapped id becomes a one-byte CAN frame
    task automatic t_error;
        ent(7'h05, 6'h0A, DIR_NONE, FN_NONE, 1'b0, 29'h777, 1'b1);
        lin_err_id <= 6'h0A;
        lin_err    <= 1'b1;
        @(posedge hclk);
        lin_err <= 1'b0;
        repeat (10) @(posedge hclk);
        `CHK("err id", {1'b0, 29'h777}, {last_can.ext, last_can.id})
        `CHK("err data", {4'h1, 64'hA}, {last_can.len, last_can.data})
    endtask
    // Mid-run reset with the cable in: PC slave, then master with a wake-up
    task automatic t_pc;
        hresetn  <= 1'b0;
        pc_cable <= 1'b1;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (8) @(posedge hclk);
        bus(1'b0, A_STAT, 32'h0);
        `CHK("pc mode", {1'b1, 3'h5}, {rd[14], rd[2:0]})
        bus(1'b1, A_PC, 32'h0000_0002);
        bus(1'b1, A_PC, 32'h0000_0303);
        @(posedge hclk);
        `CHK("wake on", 1'b1, lin_wake)
        bus(1'b0, A_PC, 32'h0);
        `CHK("pc master", 2'h3, rd[1:0])
        repeat (20) @(posedge hclk);
        `CHK("wake off", 1'b0, lin_wake)
    endtask

    // Main sequence: reset, wait for mode decision, then scenarios
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (8) @(posedge hclk);
        t_startup;
        t_forward;
        t_c2l;
        t_switch;
        t_error;
        t_pc;
        give_verdict;
    end
endmodule
